/* File: verilog/cisb_pkg.sv */
package cisb_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned SP_W = 8;
	localparam logic [7:0] SP_MAX = 8'hff;
	localparam logic [7:0] SP_RESET = 8'hff;
	localparam logic [7:0] REG_RESET = 8'h00;
	// condition code byte layout
	localparam int unsigned CC_C = 0;
	localparam int unsigned CC_Z = 1;
	localparam int unsigned CC_N = 2;
	localparam int unsigned CC_I = 3;
	localparam int unsigned CC_H = 4;
	localparam logic [4:0] CC_RESET = 5'h08;
	// operand source and destination select
	localparam logic [1:0] SEL_A = 2'h0;
	localparam logic [1:0] SEL_X = 2'h1;
	localparam logic [1:0] SEL_Y = 2'h2;
	localparam logic [1:0] SEL_M = 2'h3;
	typedef enum logic [4:0] {
		OP_NO_OPERATION,
		OP_LOAD_MOVE,
		OP_MULTIPLY_8X8,
		OP_SUBTRACT,
		OP_SUBTRACT_BORROW,
		OP_OR,
		OP_XOR,
		OP_SHIFT_LEFT_ARITH,
		OP_SHIFT_LEFT_LOGIC,
		OP_SHIFT_RIGHT_LOGIC,
		OP_SHIFT_RIGHT_ARITH,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_SWAP_NIBBLE,
		OP_TEST,
		OP_CARRY_CLEAR,
		OP_CARRY_SET,
		OP_IRQ_DISABLE,
		OP_IRQ_ENABLE,
		OP_SOFT_TRAP,
		OP_WAIT_FOR_IRQ,
		OP_STACK_POINTER_RESET,
		OP_PUSH,
		OP_POP,
		OP_BRANCH_UNSIGNED_LE
	} cisb_op_e;
endpackage : cisb_pkg

/* File: verilog/cisb_mem_if.sv */
`timescale 1ns/1ps
interface cisb_mem_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	modport core (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : cisb_mem_if

/* File: verilog/cisb_stack_mem.sv */
`timescale 1ns/1ps
module cisb_stack_mem #(
	parameter int unsigned DEPTH = 256
) (
	input wire logic sys_clk,
	cisb_mem_if.mem port
);
	logic [7:0] mem_q [DEPTH];
	logic [7:0] rd_ff;
	always_ff @(posedge sys_clk) begin
		if (port.wr_en) begin
			mem_q[port.wr_addr] <= port.wr_data;
		end
		rd_ff <= mem_q[port.rd_addr];
	end
	assign port.rd_data = rd_ff;
endmodule : cisb_stack_mem

/* File: verilog/cisb_core.sv */
`timescale 1ns/1ps
// Contract
// - unsigned less-or-equal branch taken when carry or zero is 1
// - subtract and borrow variant write a, update n z c
// - or and xor write a, update n z only
// - left shifts insert 0, old bit 7 to carry, update n z
// - logical right shift inserts 0, bit 0 to carry, n cleared
// - arithmetic right shift keeps bit 7, bit 0 to carry, n z
// - rotates go through carry both ways, update n z c
// - swap exchanges nibbles, updates n z, keeps carry
// - carry clear forces 0, carry set forces 1, nothing else
// - interrupt disable sets mask, interrupt enable clears it
// - software trap raises an interrupt and sets mask
// - wait clears mask and halts execution until interrupt
// - stack reset loads maximum pointer, flags untouched
// - push stores register or flags, pop of flags restores all five
module cisb_core (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic op_valid,
	input cisb_pkg::cisb_op_e op_code,
	input wire logic [1:0] op_dst,
	input wire logic [1:0] op_src,
	input wire logic [7:0] mem_operand,
	input wire logic irq_req,
	output logic op_ready,
	output logic [7:0] acc,
	output logic [7:0] idx_x,
	output logic [7:0] idx_y,
	output logic [7:0] stack_ptr,
	output logic [4:0] cc_flags,
	output logic mem_wr,
	output logic [7:0] mem_wdata,
	output logic branch_taken,
	output logic sw_irq,
	output logic waiting
);
	logic irq_s1_ff;
	logic irq_s2_ff;
	logic [7:0] a_ff, x_ff, y_ff, sp_ff;
	logic [7:0] nxt_a, nxt_x, nxt_y, nxt_sp;
	logic [4:0] cc_ff, nxt_cc;
	logic mw_ff, nxt_mw;
	logic [7:0] md_ff, nxt_md;
	logic br_ff, nxt_br;
	logic swi_ff, nxt_swi;
	logic wait_ff, nxt_wait;
	logic pop_ff, nxt_pop;
	logic [7:0] src_v, dst_v, res;
	logic [8:0] diff;
	logic [15:0] prod;
	logic wr_res, nz_upd, c_new;
	logic take;
	cisb_mem_if stk ();

	function automatic logic [7:0] pick(input logic [1:0] sel, input logic [7:0] a, input logic [7:0] x,
		input logic [7:0] y, input logic [7:0] m);
		unique case (sel)
			cisb_pkg::SEL_A: pick = a;
			cisb_pkg::SEL_X: pick = x;
			cisb_pkg::SEL_Y: pick = y;
			default: pick = m;
		endcase
	endfunction : pick

	cisb_stack_mem #(.DEPTH(256)) u_stack (
		.sys_clk(sys_clk),
		.port(stk)
	);

	always_ff @(posedge sys_clk) begin
		irq_s1_ff <= irq_req;
		irq_s2_ff <= irq_s1_ff;
	end

	assign op_ready = !wait_ff && !pop_ff;
	assign take = op_valid && op_ready;

	always_comb begin
		src_v = pick(op_src, a_ff, x_ff, y_ff, mem_operand);
		dst_v = pick(op_dst, a_ff, x_ff, y_ff, mem_operand);
		nxt_a = a_ff;
		nxt_x = x_ff;
		nxt_y = y_ff;
		nxt_sp = sp_ff;
		nxt_cc = cc_ff;
		nxt_mw = 1'b0;
		nxt_md = md_ff;
		nxt_br = 1'b0;
		nxt_swi = 1'b0;
		nxt_wait = wait_ff;
		nxt_pop = 1'b0;
		res = dst_v;
		wr_res = 1'b0;
		nz_upd = 1'b0;
		c_new = cc_ff[cisb_pkg::CC_C];
		diff = 9'h000;
		prod = 16'h0000;
		stk.wr_en = 1'b0;
		stk.wr_addr = sp_ff;
		stk.wr_data = src_v;
		stk.rd_addr = sp_ff + 8'h01;
		if (wait_ff && irq_s2_ff) begin
			nxt_wait = 1'b0;
		end
		if (pop_ff) begin
			if (op_dst == cisb_pkg::SEL_M) begin
				nxt_cc = stk.rd_data[4:0];
				c_new = stk.rd_data[cisb_pkg::CC_C];
			end else begin
				res = stk.rd_data;
				wr_res = 1'b1;
			end
		end else if (take) begin
			unique case (op_code)
				cisb_pkg::OP_LOAD_MOVE: begin
					res = src_v;
					wr_res = 1'b1;
					nz_upd = 1'b1;
				end
				cisb_pkg::OP_MULTIPLY_8X8: begin
					prod = dst_v * a_ff;
					if (op_dst == cisb_pkg::SEL_Y) begin
						nxt_y = prod[15:8];
					end else begin
						nxt_x = prod[15:8];
					end
					nxt_a = prod[7:0];
					nxt_cc[cisb_pkg::CC_H] = 1'b0;
					c_new = 1'b0;
				end
				cisb_pkg::OP_SUBTRACT, cisb_pkg::OP_SUBTRACT_BORROW: begin
					diff = {1'b0, a_ff} - {1'b0, mem_operand};
					if (op_code == cisb_pkg::OP_SUBTRACT_BORROW) begin
						diff = diff - {8'h00, cc_ff[cisb_pkg::CC_C]};
					end
					res = diff[7:0];
					nxt_a = res;
					nz_upd = 1'b1;
					c_new = diff[8];
				end
				cisb_pkg::OP_OR, cisb_pkg::OP_XOR: begin
					res = (op_code == cisb_pkg::OP_OR) ? (a_ff | mem_operand) : (a_ff ^ mem_operand);
					nxt_a = res;
					nz_upd = 1'b1;
				end
				cisb_pkg::OP_SHIFT_LEFT_ARITH, cisb_pkg::OP_SHIFT_LEFT_LOGIC: begin
					res = {dst_v[6:0], 1'b0};
					c_new = dst_v[7];
					wr_res = 1'b1;
					nz_upd = 1'b1;
				end
				cisb_pkg::OP_SHIFT_RIGHT_LOGIC: begin
					res = {1'b0, dst_v[7:1]};
					c_new = dst_v[0];
					wr_res = 1'b1;
					nz_upd = 1'b1;
				end
				cisb_pkg::OP_SHIFT_RIGHT_ARITH: begin
					res = {dst_v[7], dst_v[7:1]};
					c_new = dst_v[0];
					wr_res = 1'b1;
					nz_upd = 1'b1;
				end
				cisb_pkg::OP_ROTATE_LEFT_CARRY: begin
					res = {dst_v[6:0], cc_ff[cisb_pkg::CC_C]};
					c_new = dst_v[7];
					wr_res = 1'b1;
					nz_upd = 1'b1;
				end
				cisb_pkg::OP_ROTATE_RIGHT_CARRY: begin
					res = {cc_ff[cisb_pkg::CC_C], dst_v[7:1]};
					c_new = dst_v[0];
					wr_res = 1'b1;
					nz_upd = 1'b1;
				end
				cisb_pkg::OP_SWAP_NIBBLE: begin
					res = {dst_v[3:0], dst_v[7:4]};
					wr_res = 1'b1;
					nz_upd = 1'b1;
				end
				cisb_pkg::OP_TEST: begin
					res = dst_v;
					nz_upd = 1'b1;
				end
				cisb_pkg::OP_CARRY_CLEAR: c_new = 1'b0;
				cisb_pkg::OP_CARRY_SET: c_new = 1'b1;
				cisb_pkg::OP_IRQ_DISABLE: nxt_cc[cisb_pkg::CC_I] = 1'b1;
				cisb_pkg::OP_IRQ_ENABLE: nxt_cc[cisb_pkg::CC_I] = 1'b0;
				cisb_pkg::OP_SOFT_TRAP: begin
					nxt_swi = 1'b1;
					nxt_cc[cisb_pkg::CC_I] = 1'b1;
				end
				cisb_pkg::OP_WAIT_FOR_IRQ: begin
					nxt_cc[cisb_pkg::CC_I] = 1'b0;
					nxt_wait = 1'b1;
				end
				cisb_pkg::OP_STACK_POINTER_RESET: nxt_sp = cisb_pkg::SP_MAX;
				cisb_pkg::OP_PUSH: begin
					stk.wr_en = 1'b1;
					stk.wr_data = (op_src == cisb_pkg::SEL_M) ? {3'h7, cc_ff} : src_v;
					nxt_sp = sp_ff - 8'h01;
					nxt_mw = 1'b1;
					nxt_md = stk.wr_data;
				end
				cisb_pkg::OP_POP: begin
					nxt_pop = 1'b1;
					nxt_sp = sp_ff + 8'h01;
				end
				cisb_pkg::OP_BRANCH_UNSIGNED_LE: begin
					nxt_br = cc_ff[cisb_pkg::CC_C] | cc_ff[cisb_pkg::CC_Z];
				end
				default: begin
				end
			endcase
		end
		if (wr_res) begin
			unique case (op_dst)
				cisb_pkg::SEL_A: nxt_a = res;
				cisb_pkg::SEL_X: nxt_x = res;
				cisb_pkg::SEL_Y: nxt_y = res;
				default: begin
					nxt_mw = 1'b1;
					nxt_md = res;
				end
			endcase
		end
		if (nz_upd) begin
			nxt_cc[cisb_pkg::CC_N] = res[7];
			nxt_cc[cisb_pkg::CC_Z] = (res == 8'h00);
		end
		nxt_cc[cisb_pkg::CC_C] = c_new;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			a_ff <= cisb_pkg::REG_RESET;
			x_ff <= cisb_pkg::REG_RESET;
			y_ff <= cisb_pkg::REG_RESET;
			sp_ff <= cisb_pkg::SP_RESET;
			cc_ff <= cisb_pkg::CC_RESET;
			mw_ff <= 1'b0;
			md_ff <= 8'h00;
			br_ff <= 1'b0;
			swi_ff <= 1'b0;
			wait_ff <= 1'b0;
			pop_ff <= 1'b0;
		end else begin
			a_ff <= nxt_a;
			x_ff <= nxt_x;
			y_ff <= nxt_y;
			sp_ff <= nxt_sp;
			cc_ff <= nxt_cc;
			mw_ff <= nxt_mw;
			md_ff <= nxt_md;
			br_ff <= nxt_br;
			swi_ff <= nxt_swi;
			wait_ff <= nxt_wait;
			pop_ff <= nxt_pop;
		end
	end

	assign acc = a_ff;
	assign idx_x = x_ff;
	assign idx_y = y_ff;
	assign stack_ptr = sp_ff;
	assign cc_flags = cc_ff;
	assign mem_wr = mw_ff;
	assign mem_wdata = md_ff;
	assign branch_taken = br_ff;
	assign sw_irq = swi_ff;
	assign waiting = wait_ff;

	property p_branch;
		@(posedge sys_clk) disable iff (sys_rst)
		take && op_code == cisb_pkg::OP_BRANCH_UNSIGNED_LE |=> branch_taken == ($past(cc_ff[0]) | $past(cc_ff[1]));
	endproperty
	a_branch: assert property (p_branch) else $error("branch decision wrong");
	property p_branch_h;
		@(posedge sys_clk) disable iff (sys_rst)
		take && op_code == cisb_pkg::OP_BRANCH_UNSIGNED_LE && !cc_ff[0] && !cc_ff[1] |=> !branch_taken;
	endproperty
	a_branch_h: assert property (p_branch_h) else $error("branch taken with carry and zero clear");
	property p_mul;
		@(posedge sys_clk) disable iff (sys_rst)
		take && op_code == cisb_pkg::OP_MULTIPLY_8X8 && op_dst == cisb_pkg::SEL_X
		|=> {idx_x, acc} == $past(x_ff) * $past(a_ff) && cc_flags[0] == 1'b0 && cc_flags[4] == 1'b0;
	endproperty
	a_mul: assert property (p_mul) else $error("multiply result wrong");
	property p_sub;
		@(posedge sys_clk) disable iff (sys_rst)
		take && op_code == cisb_pkg::OP_SUBTRACT |=> acc == $past(a_ff) - $past(mem_operand)
			&& cc_flags[0] == ($past(mem_operand) > $past(a_ff));
	endproperty
	a_sub: assert property (p_sub) else $error("subtract wrong");
	property p_or;
		@(posedge sys_clk) disable iff (sys_rst)
		take && op_code == cisb_pkg::OP_OR |=> acc == ($past(a_ff) | $past(mem_operand))
			&& cc_flags[0] == $past(cc_ff[0]) && cc_flags[4] == $past(cc_ff[4]);
	endproperty
	a_or: assert property (p_or) else $error("or wrong");
	property p_srl;
		@(posedge sys_clk) disable iff (sys_rst)
		take && op_code == cisb_pkg::OP_SHIFT_RIGHT_LOGIC && op_dst == cisb_pkg::SEL_A
		|=> acc == {1'b0, $past(a_ff[7:1])} && cc_flags[2] == 1'b0 && cc_flags[0] == $past(a_ff[0]);
	endproperty
	a_srl: assert property (p_srl) else $error("right shift wrong");
	property p_sra;
		@(posedge sys_clk) disable iff (sys_rst)
		take && op_code == cisb_pkg::OP_SHIFT_RIGHT_ARITH && op_dst == cisb_pkg::SEL_A
		|=> acc[7] == $past(a_ff[7]) && cc_flags[0] == $past(a_ff[0]);
	endproperty
	a_sra: assert property (p_sra) else $error("arith shift wrong");
	sequence s_wait_taken;
		take && op_code == cisb_pkg::OP_WAIT_FOR_IRQ;
	endsequence
	property p_wait;
		@(posedge sys_clk) disable iff (sys_rst)
		s_wait_taken ##1 !irq_s2_ff |=> waiting && !op_ready && !cc_flags[3];
	endproperty
	a_wait: assert property (p_wait) else $error("wait not held");
	property p_rsp;
		@(posedge sys_clk) disable iff (sys_rst)
		take && op_code == cisb_pkg::OP_STACK_POINTER_RESET |=> stack_ptr == cisb_pkg::SP_MAX && $stable(cc_flags);
	endproperty
	a_rsp: assert property (p_rsp) else $error("stack reset wrong");
	property p_nop;
		@(posedge sys_clk) disable iff (sys_rst)
		take && op_code == cisb_pkg::OP_NO_OPERATION |=> $stable(cc_flags) && $stable(acc) && !mem_wr;
	endproperty
	a_nop: assert property (p_nop) else $error("no-operation changed state");
endmodule : cisb_core

/* File: verification/cisb_mem_model.sv */
`timescale 1ns/1ps
module cisb_mem_model (
	input wire logic sys_clk,
	input wire logic op_valid,
	input wire logic [7:0] stim,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_operand,
	output logic [7:0] mem_cell
);
	logic [7:0] last_ff = 8'h00;
	// released bus shows the inverse of the last byte, never a stale copy
	always_comb begin
		mem_operand = op_valid ? stim : ~last_ff;
	end
	// data cell catches every byte the core writes out
	always_ff @(posedge sys_clk) begin
		if (op_valid) begin
			last_ff <= stim;
		end
		if (mem_wr) begin
			mem_cell <= mem_wdata;
		end
	end
endmodule : cisb_mem_model

/* File: verification/cpu_instruction_semantics_b_test.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module cpu_instruction_semantics_b_test;
	localparam logic [1:0] RA = cisb_pkg::SEL_A;
	localparam logic [1:0] RX = cisb_pkg::SEL_X;
	localparam logic [1:0] RY = cisb_pkg::SEL_Y;
	localparam logic [1:0] RM = cisb_pkg::SEL_M;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic op_valid = 1'b0;
	cisb_pkg::cisb_op_e op_code = cisb_pkg::OP_NO_OPERATION;
	logic [1:0] op_dst = 2'h0;
	logic [1:0] op_src = 2'h0;
	logic [7:0] stim = 8'h00;
	logic irq_req = 1'b0;
	logic [7:0] mem_operand, acc, idx_x, idx_y, stack_ptr, mem_wdata, mem_cell;
	logic [4:0] cc_flags;
	logic op_ready, mem_wr, branch_taken, sw_irq, waiting;
	int mismatches = 0;
	int checks = 0;
	cisb_core cisb_core_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_code(op_code),
		.op_dst(op_dst), .op_src(op_src), .mem_operand(mem_operand), .irq_req(irq_req), .op_ready(op_ready),
		.acc(acc), .idx_x(idx_x), .idx_y(idx_y), .stack_ptr(stack_ptr), .cc_flags(cc_flags), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .branch_taken(branch_taken), .sw_irq(sw_irq), .waiting(waiting));
	cisb_mem_model cisb_mem_model_i (.sys_clk(sys_clk), .op_valid(op_valid), .stim(stim), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_operand(mem_operand), .mem_cell(mem_cell));
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out
	task automatic do_op(input cisb_pkg::cisb_op_e c, input logic [1:0] d, input logic [1:0] s, input logic [7:0] m);
		int n;
		n = 0;
		while (op_ready !== 1'b1 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 20) begin
			mismatches++;
			close_out();
		end else begin
			op_valid = 1'b1;
			op_code = c;
			op_dst = d;
			op_src = s;
			stim = m;
			@(negedge sys_clk);
			op_valid = 1'b0;
		end
	endtask : do_op
	task automatic op0(input cisb_pkg::cisb_op_e c);
		do_op(c, RA, RA, 8'h00);
	endtask : op0
	task automatic ld(input logic [1:0] d, input logic [7:0] m);
		do_op(cisb_pkg::OP_LOAD_MOVE, d, RM, m);
	endtask : ld
	task automatic t_alu;
		op0(cisb_pkg::OP_CARRY_SET);
		ld(RA, 8'h80);
		`CHK("acc", 8'h80, acc)
		`CHK("cc", 5'h0d, cc_flags)
		ld(RX, 8'h00);
		`CHK("x", 8'h00, idx_x)
		`CHK("cc", 5'h0b, cc_flags)
		ld(RA, 8'h05);
		op0(cisb_pkg::OP_CARRY_CLEAR);
		`CHK("cc", 5'h08, cc_flags)
		do_op(cisb_pkg::OP_SUBTRACT, RA, RM, 8'h0a);
		`CHK("acc", 8'hfb, acc)
		`CHK("cc", 5'h0d, cc_flags)
		do_op(cisb_pkg::OP_SUBTRACT_BORROW, RA, RM, 8'hfa);
		`CHK("acc", 8'h00, acc)
		`CHK("cc", 5'h0a, cc_flags)
		ld(RA, 8'hf0);
		op0(cisb_pkg::OP_CARRY_SET);
		`CHK("cc", 5'h0d, cc_flags)
		do_op(cisb_pkg::OP_OR, RA, RM, 8'h0f);
		`CHK("acc", 8'hff, acc)
		`CHK("cc", 5'h0d, cc_flags)
		do_op(cisb_pkg::OP_XOR, RA, RM, 8'hff);
		`CHK("acc", 8'h00, acc)
		`CHK("cc", 5'h0b, cc_flags)
	endtask : t_alu
	task automatic t_shift;
		cisb_pkg::cisb_op_e ops[7] = '{cisb_pkg::OP_SHIFT_LEFT_ARITH, cisb_pkg::OP_SHIFT_LEFT_LOGIC,
			cisb_pkg::OP_SHIFT_RIGHT_LOGIC, cisb_pkg::OP_SHIFT_RIGHT_ARITH, cisb_pkg::OP_ROTATE_LEFT_CARRY,
			cisb_pkg::OP_ROTATE_RIGHT_CARRY, cisb_pkg::OP_SWAP_NIBBLE};
		logic [7:0] ins[7] = '{8'h01, 8'h80, 8'h81, 8'h80, 8'h80, 8'h01, 8'h3c};
		logic [7:0] outs[7] = '{8'h02, 8'h00, 8'h40, 8'hc0, 8'h01, 8'h00, 8'hc3};
		logic cin[7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		logic cout[7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
		for (int k = 0; k < 7; k++) begin
			ld(RA, ins[k]);
			op0(cin[k] ? cisb_pkg::OP_CARRY_SET : cisb_pkg::OP_CARRY_CLEAR);
			op0(ops[k]);
			`CHK("acc", outs[k], acc)
			`CHK("cc", {2'b01, outs[k][7], outs[k] == 8'h00, cout[k]}, cc_flags)
		end
		do_op(cisb_pkg::OP_SHIFT_LEFT_ARITH, RM, RM, 8'h40);
		`CHK("wr", 1'b1, mem_wr)
		`CHK("wdata", 8'h80, mem_wdata)
		`CHK("acc", 8'hc3, acc)
		`CHK("cc", 5'h0c, cc_flags)
		@(negedge sys_clk);
		`CHK("cell", 8'h80, mem_cell)
		`CHK("wr", 1'b0, mem_wr)
	endtask : t_shift
	task automatic t_mul_br;
		ld(RA, 8'h00);
		op0(cisb_pkg::OP_CARRY_SET);
		do_op(cisb_pkg::OP_TEST, RM, RM, 8'h80);
		`CHK("acc", 8'h00, acc)
		`CHK("cc", 5'h0d, cc_flags)
		`CHK("wr", 1'b0, mem_wr)
		ld(RA, 8'hff);
		ld(RX, 8'hff);
		op0(cisb_pkg::OP_CARRY_SET);
		do_op(cisb_pkg::OP_MULTIPLY_8X8, RX, RA, 8'h00);
		`CHK("x", 8'hfe, idx_x)
		`CHK("acc", 8'h01, acc)
		`CHK("cc", 5'h0c, cc_flags)
		ld(RY, 8'h10);
		ld(RA, 8'h20);
		do_op(cisb_pkg::OP_MULTIPLY_8X8, RY, RA, 8'h00);
		`CHK("y", 8'h02, idx_y)
		`CHK("acc", 8'h00, acc)
		for (int k = 0; k < 3; k++) begin
			ld(RA, (k == 2) ? 8'h00 : 8'h01);
			op0((k == 1) ? cisb_pkg::OP_CARRY_SET : cisb_pkg::OP_CARRY_CLEAR);
			op0(cisb_pkg::OP_BRANCH_UNSIGNED_LE);
			`CHK("br", k != 0, branch_taken)
		end
		op0(cisb_pkg::OP_NO_OPERATION);
		`CHK("acc", 8'h00, acc)
		`CHK("cc", 5'h0a, cc_flags)
		`CHK("wr", 1'b0, mem_wr)
	endtask : t_mul_br
	task automatic t_stack;
		ld(RA, 8'h5a);
		op0(cisb_pkg::OP_CARRY_SET);
		do_op(cisb_pkg::OP_PUSH, RM, RA, 8'h00);
		`CHK("wdata", 8'h5a, mem_wdata)
		`CHK("sp", 8'hfe, stack_ptr)
		do_op(cisb_pkg::OP_PUSH, RM, RM, 8'h00);
		`CHK("wdata", 8'he9, mem_wdata)
		op0(cisb_pkg::OP_CARRY_CLEAR);
		do_op(cisb_pkg::OP_POP, RM, RM, 8'h00);
		@(negedge sys_clk);
		`CHK("cc", 5'h09, cc_flags)
		do_op(cisb_pkg::OP_POP, RX, RM, 8'h00);
		@(negedge sys_clk);
		`CHK("x", 8'h5a, idx_x)
		`CHK("sp", 8'hff, stack_ptr)
		do_op(cisb_pkg::OP_PUSH, RM, RA, 8'h00);
		op0(cisb_pkg::OP_STACK_POINTER_RESET);
		`CHK("sp", cisb_pkg::SP_MAX, stack_ptr)
		`CHK("cc", 5'h09, cc_flags)
	endtask : t_stack
	task automatic t_irq;
		int n;
		op0(cisb_pkg::OP_IRQ_ENABLE);
		`CHK("mask", 1'b0, cc_flags[cisb_pkg::CC_I])
		op0(cisb_pkg::OP_IRQ_DISABLE);
		`CHK("mask", 1'b1, cc_flags[cisb_pkg::CC_I])
		op0(cisb_pkg::OP_IRQ_ENABLE);
		op0(cisb_pkg::OP_SOFT_TRAP);
		`CHK("trap", 1'b1, sw_irq)
		`CHK("mask", 1'b1, cc_flags[cisb_pkg::CC_I])
		op0(cisb_pkg::OP_WAIT_FOR_IRQ);
		`CHK("wait", 1'b1, waiting)
		`CHK("rdy", 1'b0, op_ready)
		`CHK("mask", 1'b0, cc_flags[cisb_pkg::CC_I])
		irq_req = 1'b1;
		n = 0;
		while (waiting !== 1'b0 && n < 10) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK("wake", 1'b1, n < 10)
		irq_req = 1'b0;
	endtask : t_irq
	initial begin
		repeat (3) @(negedge sys_clk);
		sys_rst = 1'b0;
		`CHK("sp", 8'hff, stack_ptr)
		`CHK("cc", 5'h08, cc_flags)
		t_alu();
		t_shift();
		t_mul_br();
		t_stack();
		t_irq();
		close_out();
	end
endmodule : cpu_instruction_semantics_b_test
